/* File: rtl/vms_pkg.sv */
// Package: encodings, widths and constants for the vector element sizing block
package vms_pkg;

  // Register file geometry
  localparam int NUM_VREGS     = 32;
  localparam int NUM_PREGS     = 16;
  localparam int VREG_IDX_W    = 5;
  localparam int PREG_IDX_W    = 4;
  localparam int VLEN_BITS     = 128;
  localparam int PLEN_BITS     = VLEN_BITS / 8;

  // Memory access suffix codes
  typedef enum logic [2:0] {
    VMS_ACC_UB = 3'h0,   // Unsigned byte
    VMS_ACC_UH = 3'h1,   // Unsigned half / half float
    VMS_ACC_UW = 3'h2,   // Unsigned word / single float
    VMS_ACC_UD = 3'h3,   // Unsigned double / double float
    VMS_ACC_SB = 3'h4,   // Signed byte access
    VMS_ACC_SH = 3'h5,   // Signed half access
    VMS_ACC_SW = 3'h6    // Signed word access
  } vms_acc_e;

  // Register element size codes (log2 of bytes)
  typedef enum logic [1:0] {
    VMS_ESZ_B = 2'h0,
    VMS_ESZ_H = 2'h1,
    VMS_ESZ_S = 2'h2,
    VMS_ESZ_D = 2'h3
  } vms_esz_e;

  // Operation kinds
  typedef enum logic [1:0] {
    VMS_OP_LOAD  = 2'h0,
    VMS_OP_STORE = 2'h1,
    VMS_OP_PREF  = 2'h2,
    VMS_OP_NOWR  = 2'h3  // Predicate-only, no vector write
  } vms_op_e;

  // Predicate forms
  localparam logic PRED_ZEROING = 1'b0;
  localparam logic PRED_MERGING = 1'b1;

  // Field positions
  localparam int ACC_SIGN_BIT = 2;
  localparam logic [1:0] ESZ_LSB_ONLY = 2'h0;

endpackage

/* File: rtl/vms_sizer.sv */
// Vector memory element sizing: decode, convert and predicate one vector transfer
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Holds thirty-two vector registers and sixteen predicate registers, reached by index.
// - Zeroing form writes zero into inactive destination elements.
// - Merging form has no effect: loads, the only writes, always zero inactive destination elements.
// - Non-writing instructions use the predicate only to pick active elements.
// - Memory access size and sign come from suffix code, not element size.
// - Codes for unsigned 8, 16, 32, 64 bit accesses, also float data.
// - Three signed codes for 8, 16, 32 bit accesses sign-extend loads.
// - Element size must be at least access size; larger means unpacked.
// - Unpacked loads widen each element by sign or zero extension.
// - Unpacked stores keep only the low bits of each element.
// - Equal sizes mean packed; signed codes are not allowed packed.
// - Prefetch goes out as a read or write hint, never a data transfer.
// - Every predicated load zeroes inactive destination elements.
// - Prefetch changes no architectural state.
module vms_sizer
  import vms_pkg::*;
#(
  parameter int VLEN = vms_pkg::VLEN_BITS
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        req_valid,
  input  wire vms_pkg::vms_op_e            req_op,
  input  wire vms_pkg::vms_acc_e           req_acc,
  input  wire vms_pkg::vms_esz_e           req_esz,
  input  wire logic                        req_pred_form,
  input  wire logic                        req_pf_write,
  input  wire logic [vms_pkg::VREG_IDX_W-1:0] req_vreg,
  input  wire logic [vms_pkg::PREG_IDX_W-1:0] req_preg,
  input  wire logic [VLEN-1:0]             mem_rdata,
  input  wire logic                        wr_vreg_en,
  input  wire logic [vms_pkg::VREG_IDX_W-1:0] wr_vreg_idx,
  input  wire logic [VLEN-1:0]             wr_vreg_data,
  input  wire logic                        wr_preg_en,
  input  wire logic [vms_pkg::PREG_IDX_W-1:0] wr_preg_idx,
  input  wire logic [VLEN/8-1:0]           wr_preg_data,
  output logic                             undef_r,
  output logic                             done_r,
  output logic                             mem_wr_r,
  output logic [VLEN-1:0]                  mem_wdata_r,
  output logic [VLEN/8-1:0]                mem_wstrb_r,
  output logic                             pf_valid_r,
  output logic                             pf_write_r,
  output logic [VLEN/8-1:0]                pf_mask_r,
  output logic [VLEN-1:0]                  rd_vreg_r
);
  import vms_pkg::*;

  localparam int NB = VLEN / 8;

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rst_q1_r;
  logic rst_q2_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end
  wire logic rstn_s = rst_q2_r;

  // ------------------------------------------------------------
  // Register files
  // ------------------------------------------------------------
  logic [VLEN-1:0] vregs_r [NUM_VREGS];
  logic [NB-1:0]   pregs_r [NUM_PREGS];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Access size in log2 bytes
  function automatic logic [1:0] acc_log2(input vms_acc_e a);
    return a[1:0];
  endfunction

  // Expand predicate: one bit per byte, lowest bit of element governs
  function automatic logic [NB-1:0] byte_mask(input logic [NB-1:0] p, input logic [1:0] esz);
    logic [NB-1:0] m;
    m = '0;
    for (int i = 0; i < NB; i++) begin
      m[i] = p[(i >> esz) << esz];
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire logic [1:0] acc_sz    = acc_log2(req_acc);
  wire logic       acc_sgn   = req_acc[ACC_SIGN_BIT];
  wire logic       acc_bad   = (req_acc == 3'h7);
  wire logic       oversize  = (acc_sz > req_esz);
  wire logic       packed_x  = (acc_sz == req_esz);
  wire logic       unpacked  = (req_esz > acc_sz);
  wire logic       sgn_pack  = acc_sgn && packed_x;
  wire logic       is_undef  = req_valid && (acc_bad || oversize || sgn_pack);
  wire logic       go        = req_valid && !is_undef;

  wire logic [NB-1:0]   pred  = pregs_r[req_preg];
  wire logic [VLEN-1:0] old_v = vregs_r[req_vreg];
  wire logic [NB-1:0]   emask = byte_mask(pred, req_esz);

  // ------------------------------------------------------------
  // Load widening and store truncation
  // ------------------------------------------------------------
  logic [VLEN-1:0] ld_conv;
  logic [VLEN-1:0] st_conv;
  logic [NB-1:0]   st_strb;
  always_comb begin
    int ebytes;
    int abytes;
    int nel;
    logic [63:0] raw;
    logic        sbit;
    raw     = '0;
    sbit    = 1'b0;
    ld_conv = '0;
    st_conv = '0;
    st_strb = '0;
    ebytes  = 1 << req_esz;
    abytes  = 1 << acc_sz;
    nel     = NB >> req_esz;
    for (int e = 0; e < NB; e++) begin
      if (e < nel) begin
        // Memory element e sits packed at e*abytes in the fetched beat
        raw = '0;
        for (int b = 0; b < 8; b++) begin
          if (b < abytes) raw[b*8 +: 8] = mem_rdata[(e*abytes + b)*8 +: 8];
        end
        sbit = raw[abytes*8-1];
        for (int b = 0; b < 8; b++) begin
          if (b < ebytes) begin
            if (b < abytes) begin
              ld_conv[(e*ebytes + b)*8 +: 8] = raw[b*8 +: 8];
            end else begin
              ld_conv[(e*ebytes + b)*8 +: 8] = (acc_sgn && unpacked && sbit) ? 8'hff : 8'h00;
            end
          end
          if (b < abytes) begin
            st_conv[(e*abytes + b)*8 +: 8] = old_v[(e*ebytes + b)*8 +: 8];
            st_strb[e*abytes + b] = pred[e*ebytes];
          end
        end
      end
    end
  end

  // Predicated merge of converted load data
  wire logic zero_form = (req_pred_form == PRED_ZEROING) || (req_op == VMS_OP_LOAD);
  logic [VLEN-1:0] ld_final;
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      ld_final[i*8 +: 8] = emask[i] ? ld_conv[i*8 +: 8] :
                           (zero_form ? 8'h00 : old_v[i*8 +: 8]);
    end
  end

  wire logic do_vwr  = go && (req_op == VMS_OP_LOAD);
  wire logic do_st   = go && (req_op == VMS_OP_STORE);
  wire logic do_pf   = go && (req_op == VMS_OP_PREF);

  // ------------------------------------------------------------
  // Register file writes
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (do_vwr) begin
      vregs_r[req_vreg] <= ld_final;
    end else if (wr_vreg_en) begin
      vregs_r[wr_vreg_idx] <= wr_vreg_data;
    end
    if (wr_preg_en) begin
      pregs_r[wr_preg_idx] <= wr_preg_data;
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn_s) begin
    if (!rstn_s) begin
      undef_r     <= 1'b0;
      done_r      <= 1'b0;
      mem_wr_r    <= 1'b0;
      mem_wdata_r <= '0;
      mem_wstrb_r <= '0;
      pf_valid_r  <= 1'b0;
      pf_write_r  <= 1'b0;
      pf_mask_r   <= '0;
      rd_vreg_r   <= '0;
    end else begin
      undef_r     <= is_undef;
      done_r      <= go;
      mem_wr_r    <= do_st;
      mem_wdata_r <= do_st ? st_conv : '0;
      mem_wstrb_r <= do_st ? st_strb : '0;
      pf_valid_r  <= do_pf;
      pf_write_r  <= do_pf && req_pf_write;
      pf_mask_r   <= do_pf ? emask : '0;
      rd_vreg_r   <= do_vwr ? ld_final : old_v;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_SIGNED_PACKED_UNDEF: assert property (@(posedge clk) disable iff (!rstn_s)
    (req_valid && req_acc[ACC_SIGN_BIT] && (req_acc[1:0] == req_esz)) |=> undef_r)
    else $error("signed packed access not rejected");
  AST_OVERSIZE_UNDEF: assert property (@(posedge clk) disable iff (!rstn_s)
    (req_valid && (req_acc[1:0] > req_esz)) |=> (undef_r && !done_r && !mem_wr_r))
    else $error("oversized access not rejected");
  AST_GOOD_DONE: assert property (@(posedge clk) disable iff (!rstn_s)
    (req_valid && req_acc != 3'h7 && !req_acc[ACC_SIGN_BIT] && req_acc[1:0] <= req_esz) |=> done_r)
    else $error("legal unsigned access not accepted");
  AST_PF_NO_STORE: assert property (@(posedge clk) disable iff (!rstn_s)
    pf_valid_r |-> !mem_wr_r)
    else $error("prefetch produced a store");
  AST_PF_HOLD: assert property (@(posedge clk) disable iff (!rstn_s)
    (go && req_op == VMS_OP_PREF) |=> (rd_vreg_r == $past(old_v)))
    else $error("prefetch changed vector state");
  AST_LOAD_ZERO: assert property (@(posedge clk) disable iff (!rstn_s)
    (do_vwr && emask == '0) |=> (rd_vreg_r == '0))
    else $error("inactive load elements not zeroed");
  AST_ZX_BYTE: assert property (@(posedge clk) disable iff (!rstn_s)
    (do_vwr && req_acc == VMS_ACC_UB && req_esz == VMS_ESZ_H && emask[0]) |=> (rd_vreg_r[15:8] == 8'h00))
    else $error("unsigned byte not zero extended");
  AST_SX_BYTE: assert property (@(posedge clk) disable iff (!rstn_s)
    (do_vwr && req_acc == VMS_ACC_SB && req_esz == VMS_ESZ_H && emask[0] && mem_rdata[7])
      |=> (rd_vreg_r[15:8] == 8'hff))
    else $error("signed byte not sign extended");
  AST_STORE_TRUNC: assert property (@(posedge clk) disable iff (!rstn_s)
    (do_st && req_acc == VMS_ACC_UB && req_esz == VMS_ESZ_D) |=> (mem_wdata_r[VLEN-1:NB] == '0))
    else $error("store not truncated");

  COV_UNPACK_LOAD: cover property (@(posedge clk) disable iff (!rstn_s) do_vwr && unpacked);
  COV_STORE: cover property (@(posedge clk) disable iff (!rstn_s) do_st);
  COV_PREF: cover property (@(posedge clk) disable iff (!rstn_s) do_pf && req_pf_write);
  COV_UNDEF: cover property (@(posedge clk) disable iff (!rstn_s) is_undef);

endmodule

`default_nettype wire

/* File: verif/vms_mem_model.sv */
// Memory model that serves element loads for the sizing block
`timescale 1ns/10ps
`default_nettype none
module vms_mem_model (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         rd_req,
  input  wire logic [127:0] fill,
  output logic      [127:0] mem_rdata
);
  logic [127:0] junk_r;
  // Off-request pattern moves every cycle so stale data never looks valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      junk_r <= 128'h5a;
    else
      junk_r <= {junk_r[126:0], ~junk_r[127]};
  end
  // Data only while a load asks for it
  assign mem_rdata = rd_req ? fill : junk_r;
endmodule
`default_nettype wire

/* File: verif/vms_sizer_tb.sv */
// Self-checking testbench for the vector element sizing block
`timescale 1ns/10ps
`default_nettype none
module vms_sizer_tb;
  import vms_pkg::*;
  typedef struct {logic und; logic wr; logic pf; logic pfw; logic [127:0] rd; logic [127:0] wd;
                  logic [127:0] wb; logic [15:0] ws; logic [15:0] pm;} vms_note_s;
  logic         clk, resetn, req_valid, req_pred_form, req_pf_write, wr_vreg_en, wr_preg_en, rd_req;
  logic         undef_r, done_r, mem_wr_r, pf_valid_r, pf_write_r;
  logic [127:0] mem_rdata, wr_vreg_data, fill, mem_wdata_r, rd_vreg_r;
  logic [127:0] vexp [32];
  logic [15:0]  wr_preg_data, mem_wstrb_r, pf_mask_r;
  logic [15:0]  pexp [16];
  logic [4:0]   req_vreg, wr_vreg_idx;
  logic [3:0]   req_preg, wr_preg_idx;
  vms_op_e      req_op;
  vms_acc_e     req_acc;
  vms_esz_e     req_esz;
  logic [31:0]  seed = 32'hc7ca;
  int           n_fail = 0;
  int           compares = 0;
  vms_note_s    q[$];

  // Clock and load request decode for the memory model
  always #5 clk = ~clk;
  assign rd_req = req_valid && req_op == VMS_OP_LOAD;

  vms_sizer uut (.clk, .resetn, .req_valid, .req_op, .req_acc, .req_esz, .req_pred_form, .req_pf_write,
    .req_vreg, .req_preg, .mem_rdata, .wr_vreg_en, .wr_vreg_idx, .wr_vreg_data, .wr_preg_en, .wr_preg_idx,
    .wr_preg_data, .undef_r, .done_r, .mem_wr_r, .mem_wdata_r, .mem_wstrb_r, .pf_valid_r, .pf_write_r,
    .pf_mask_r, .rd_vreg_r);
  vms_mem_model mem (.clk, .resetn, .rd_req, .fill, .mem_rdata);

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Expected load image, store beat and byte masks of one transfer
  function automatic void calc(input logic [2:0] a, input logic [1:0] z, input logic [15:0] p,
    input logic [127:0] s, output logic [127:0] ld, st, sb, output logic [15:0] sm, pm);
    int eb;
    int ab;
    eb = 1 << z;
    ab = 1 << a[1:0];
    ld = '0;
    st = '0;
    sb = '0;
    sm = '0;
    pm = '0;
    for (int e = 0; e < 16 / eb; e++) if (p[e * eb]) begin
      for (int b = 0; b < eb; b++) begin
        ld[(e*eb+b)*8 +: 8] = (b < ab) ? s[(e*ab+b)*8 +: 8] : {8{a[2] & s[(e*ab+ab)*8-1]}};
        pm[e*eb+b] = 1'b1;
      end
      for (int b = 0; b < ab; b++) begin
        st[(e*ab+b)*8 +: 8] = s[(e*eb+b)*8 +: 8];
        sb[(e*ab+b)*8 +: 8] = 8'hff;
        sm[e*ab+b] = 1'b1;
      end
    end
  endfunction

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Offer one request and note what must come back
  task automatic req(input int op, input int acc, input int esz, input int v);
    vms_note_s n;
    logic [2:0] a;
    logic [1:0] z;
    logic [127:0] f, ld, st, sb;
    logic [15:0] sm, pm;
    logic fm;
    a = 3'(acc);
    z = 2'(esz);
    f = {rnd(), rnd(), rnd(), rnd()};
    fm = (op == 2) ? 1'(v) : seed[3];
    n = '{default: '0};
    n.und = (a == 3'h7 || a[1:0] > z || (a[2] && a[1:0] == z));
    if (!n.und)
      calc(a, z, pexp[v % 16], op == 0 ? f : vexp[v], ld, st, sb, sm, pm);
    n.rd = (op == 0 && !n.und) ? ld : vexp[v];
    if (op == 0 && !n.und)
      vexp[v] = ld;
    n.wr = (op == 1);
    n.pf = (op == 2);
    n.pfw = fm;
    n.wd = st;
    n.wb = sb;
    n.ws = sm;
    n.pm = pm;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= vms_op_e'(op);
    req_acc <= vms_acc_e'(a);
    req_esz <= vms_esz_e'(z);
    req_pred_form <= fm;
    req_pf_write <= fm;
    req_vreg <= 5'(v);
    req_preg <= 4'(v % 16);
    fill <= f;
    q.push_back(n);
  endtask

  // Answer watcher takes the oldest note per result
  always @(negedge clk) begin
    vms_note_s n;
    if (resetn && (undef_r === 1'b1 || done_r === 1'b1)) begin
      if (q.size() == 0) begin
        chk(1'b0, "answer with nothing pending");
      end else begin
        n = q.pop_front();
        chk(undef_r === n.und && done_r === !n.und, "undef or done wrong");
        chk(rd_vreg_r === n.rd, "vector register wrong");
        if (n.und) begin
          chk(mem_wr_r === 1'b0 && pf_valid_r === 1'b0, "refused access acted");
        end else begin
          chk(mem_wr_r === n.wr && (!n.wr || mem_wstrb_r === n.ws), "store strobes wrong");
          chk(!n.wr || (mem_wdata_r & n.wb) === n.wd, "store data wrong");
          chk(pf_valid_r === n.pf && (!n.pf || pf_mask_r === n.pm), "prefetch mask wrong");
          chk(!n.pf || pf_write_r === n.pfw, "prefetch kind wrong");
        end
      end
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    req_valid = 1'b0;
    req_op = VMS_OP_LOAD;
    req_acc = VMS_ACC_UB;
    req_esz = VMS_ESZ_B;
    req_pred_form = 1'b0;
    req_pf_write = 1'b0;
    req_vreg = '0;
    req_preg = '0;
    fill = '0;
    wr_vreg_en = 1'b0;
    wr_vreg_idx = '0;
    wr_vreg_data = '0;
    wr_preg_en = 1'b0;
    wr_preg_idx = '0;
    wr_preg_data = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      vexp[i] = {rnd(), rnd(), rnd(), rnd()};
      // Low bit set so extension checks see an active element; one predicate all clear
      pexp[i % 16] = (i % 16 == 14) ? 16'h0 : (16'(rnd()) | 16'h1);
      wr_vreg_en <= 1'b1;
      wr_vreg_idx <= 5'(i);
      wr_vreg_data <= vexp[i];
      wr_preg_en <= 1'b1;
      wr_preg_idx <= 4'(i % 16);
      wr_preg_data <= pexp[i % 16];
    end
    @(posedge clk);
    wr_vreg_en <= 1'b0;
    wr_preg_en <= 1'b0;
    for (int r = 0; r < 8; r++)
      for (int op = 0; op < 2; op++)
        for (int c = 0; c < 32; c++) req(op, c % 8, c / 8, c);
    for (int c = 0; c < 8; c++) req(2, c % 4, c % 4, c);
    for (int c = 0; c < 32; c++) req(3, 0, 0, c);
    @(posedge clk);
    req_valid <= 1'b0;
    for (int t = 0; t < 20 && q.size() > 0; t++) @(posedge clk);
    chk(q.size() == 0, "answers missing");
    close_out();
  end
endmodule
`default_nettype wire
